// ---- hdl/adc_input_defs.svh ----
// Constants for the converter input-configuration and coding block
`ifndef ADC_INPUT_DEFS_SVH
`define ADC_INPUT_DEFS_SVH
`define TRACK_EDGE      4'hD
`define LAST_EDGE       4'hE
`define CNT_ZERO        4'h0
`define SEL_PAIR_LSB    1
`define ADDR_SE_MAX     3'h5
`define ACQ_TIME_NS     300
`define CLK_PERIOD_NS   20
`define ACQ_CYCLES      ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACQ_W           5
`endif

// ---- hdl/adc_input_pkg.sv ----
// Types shared by the converter input-configuration block
package adc_input_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_FULL_DIFF,
    MODE_PSEUDO_DIFF
  } input_mode_t;

  typedef enum logic {
    CODE_STRAIGHT,
    CODE_TWOS
  } coding_t;

  typedef struct packed {
    input_mode_t mode;
    logic [5:0]  posSel;
    logic [5:0]  negSel;
    logic        negGround;
    logic        doubleRange;
    coding_t     coding;
    logic [1:0]  lsbShift;
    logic        addrValid;
  } conv_cfg_t;
endpackage

// ---- hdl/adc_input_config.sv ----
// Input selection, acquisition tracking and result coding for a dual converter
`timescale 1ns/1ps
`default_nettype none
`include "adc_input_defs.svh"

// Operation
// R1: Select low differential pairs, high single-ended
// R2: Host holds input type through acquisition
// R3: Return to track on thirteenth rising edge
// R4: Input type change acts immediately
// R5: Host sets address before acquisition
// R6: Mode change restarts acquisition period
// R7: Single-ended address zero-five selects input, ground
// R8: Differential: pair from upper bits, bit0 pseudo
// R9: Host holds range until third falling edge
// R10: Range low single span, high double
// R11: Twos complement unless single range non-full-diff
// R12: Code unit scales with mode and range
// R13: Conversion starts on chip-select falling, fourteen clocks
module adc_input_config (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  // Host pins
  input  wire logic                     csN,
  input  wire logic                     sclk,
  input  wire logic                     inputTypeSelect,
  input  wire logic                     chanAddrBit0,
  input  wire logic                     chanAddrBit1,
  input  wire logic                     chanAddrBit2,
  input  wire logic                     rangeSelect,
  // Configuration to the analog front end
  output var adc_input_pkg::conv_cfg_t  cfg,
  output logic                          trackMode,
  output logic                          converting,
  output logic                          convDone,
  output logic                          acqDone,
  output logic                          acqRestart
);

  logic [1:0] csSync, sclkSync, typeSync, rangeSync;
  logic [2:0] addrSync0, addrSync1;
  logic       csQ, sclkQ;
  logic [3:0] riseCnt_q;
  logic [3:0] fallCnt_q;
  logic       converting_q;
  logic       track_q;
  logic       rangeLatch_q;
  logic [`ACQ_W-1:0] acqCnt_q;
  adc_input_pkg::conv_cfg_t  cfg_d, cfg_q;
  adc_input_pkg::input_mode_t modePrev_q;
  logic       done_q, restart_q;

  // Two-stage synchronisers for every pin
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Serial clock idles high; resetting low would fake a rising edge
      csSync    <= 2'h3;
      sclkSync  <= 2'h3;
      typeSync  <= 2'h0;
      rangeSync <= 2'h0;
      addrSync0 <= 3'h0;
      addrSync1 <= 3'h0;
      csQ       <= 1'b1;
      sclkQ     <= 1'b1;
    end else begin
      csSync    <= {csSync[0], csN};
      sclkSync  <= {sclkSync[0], sclk};
      typeSync  <= {typeSync[0], inputTypeSelect};
      rangeSync <= {rangeSync[0], rangeSelect};
      addrSync0 <= {chanAddrBit2, chanAddrBit1, chanAddrBit0};
      addrSync1 <= addrSync0;
      csQ       <= csSync[1];
      sclkQ     <= sclkSync[1];
    end
  end

  logic csFall, sclkRise, sclkFall;
  assign csFall   = csQ & ~csSync[1];
  assign sclkRise = ~sclkQ & sclkSync[1];
  assign sclkFall = sclkQ & ~sclkSync[1];

  // Frame sequencing: conversion from chip-select falling edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      converting_q <= 1'b0;
      track_q      <= 1'b1;
      riseCnt_q    <= `CNT_ZERO;
      fallCnt_q    <= `CNT_ZERO;
      done_q       <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (csFall) begin
        converting_q <= 1'b1; // [R13]
        track_q      <= 1'b0;
        riseCnt_q    <= `CNT_ZERO;
        fallCnt_q    <= `CNT_ZERO;
      end else if (csSync[1]) begin
        converting_q <= 1'b0;
        track_q      <= 1'b1;
      end else if (converting_q) begin
        if (sclkRise) begin
          riseCnt_q <= riseCnt_q + 4'h1;
          if (riseCnt_q + 4'h1 == `TRACK_EDGE) begin
            track_q <= 1'b1; // [R3]
          end
        end
        if (sclkFall) begin
          fallCnt_q <= fallCnt_q + 4'h1;
          if (fallCnt_q + 4'h1 == `LAST_EDGE) begin
            converting_q <= 1'b0; // [R13]
            done_q       <= 1'b1;
          end
        end
      end
    end
  end

  // Range is sampled at chip-select fall; host holds it to third falling edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rangeLatch_q <= 1'b0;
    end else if (csFall || !converting_q) begin
      rangeLatch_q <= rangeSync[1]; // [R9]
    end
  end

  // Decode of mode, channel and coding
  always_comb begin
    logic [2:0] addr;
    logic [1:0] pair;
    addr  = addrSync1;
    pair  = addr[2:`SEL_PAIR_LSB];
    cfg_d = '0;
    cfg_d.doubleRange = rangeLatch_q; // [R10]
    if (typeSync[1]) begin
      cfg_d.mode      = adc_input_pkg::MODE_SINGLE; // [R1]
      cfg_d.addrValid = (addr <= `ADDR_SE_MAX); // [R7]
      cfg_d.posSel    = cfg_d.addrValid ? 6'h01 << addr : 6'h00;
      cfg_d.negGround = 1'b1; // [R7]
    end else begin
      cfg_d.mode      = addr[0] ? adc_input_pkg::MODE_PSEUDO_DIFF
                                : adc_input_pkg::MODE_FULL_DIFF; // [R8]
      cfg_d.addrValid = (pair != 2'h3);
      cfg_d.posSel    = cfg_d.addrValid ? 6'h01 << {pair, 1'b0} : 6'h00; // [R8]
      cfg_d.negSel    = cfg_d.addrValid ? 6'h02 << {pair, 1'b0} : 6'h00;
    end
    // [R11]
    if (rangeLatch_q || cfg_d.mode == adc_input_pkg::MODE_FULL_DIFF) begin
      cfg_d.coding = adc_input_pkg::CODE_TWOS;
    end else begin
      cfg_d.coding = adc_input_pkg::CODE_STRAIGHT;
    end
    // [R12]
    cfg_d.lsbShift = {1'b0, rangeLatch_q}
                   + {1'b0, cfg_d.mode != adc_input_pkg::MODE_SINGLE};
  end

  // Configuration follows the pins at all times except range, held from chip-select fall, so a type or address change mid-conversion lands
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d; // [R4]
    end
  end

  // Acquisition timer restarts on each return to track or mode change
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acqCnt_q   <= '0;
      modePrev_q <= adc_input_pkg::MODE_SINGLE;
      restart_q  <= 1'b0;
    end else begin
      modePrev_q <= cfg_q.mode;
      restart_q  <= 1'b0;
      if (!track_q) begin
        acqCnt_q <= '0;
      end else if (cfg_q.mode != modePrev_q) begin
        acqCnt_q  <= '0; // [R6]
        restart_q <= 1'b1;
      end else if (acqCnt_q != `ACQ_W'(`ACQ_CYCLES)) begin
        acqCnt_q <= acqCnt_q + `ACQ_W'(1);
      end
    end
  end

  assign cfg        = cfg_q;
  assign trackMode  = track_q;
  assign converting = converting_q;
  assign convDone   = done_q;
  assign acqDone    = track_q && (acqCnt_q == `ACQ_W'(`ACQ_CYCLES));
  assign acqRestart = restart_q;

  // Checks
  sequence frameStart_s;
    csFall;
  endsequence

  track_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R3]
    (converting_q && !csSync[1] && sclkRise && riseCnt_q == `TRACK_EDGE - 4'h1) |=> track_q)
    else $error("Track not resumed on thirteenth rise");
  frame_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R13]
    frameStart_s |=> converting_q && !track_q)
    else $error("Conversion not started on chip-select fall");
  se_select_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R7]
    (cfg_q.mode == adc_input_pkg::MODE_SINGLE && cfg_q.addrValid)
      |-> cfg_q.negGround && $onehot(cfg_q.posSel))
    else $error("Single-ended select wrong");
  diff_select_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R8]
    (cfg_q.mode != adc_input_pkg::MODE_SINGLE) |-> (cfg_q.negSel == (cfg_q.posSel << 1)))
    else $error("Differential pair wrong");
  coding_rule_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R11]
    (!cfg_q.doubleRange && cfg_q.mode != adc_input_pkg::MODE_FULL_DIFF)
      |-> cfg_q.coding == adc_input_pkg::CODE_STRAIGHT)
    else $error("Coding wrong");
  lsb_scale_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R12]
    (cfg_q.doubleRange && cfg_q.mode != adc_input_pkg::MODE_SINGLE) |-> cfg_q.lsbShift == 2'h2)
    else $error("Code unit wrong");
  mode_follow_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R1]
    typeSync[1] |=> cfg_q.mode == adc_input_pkg::MODE_SINGLE)
    else $error("Input type not applied");
  acq_restart_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R6]
    (track_q && $changed(cfg_q.mode)) |=> !acqDone [*2])
    else $error("Acquisition not restarted");
  range_span_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R10]
    !converting_q |=> ##1 cfg_q.doubleRange == $past(rangeSync[1], 2))
    else $error("Range not applied");
  range_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R9]
    converting_q |=> $stable(rangeLatch_q))
    else $error("Range changed during conversion");

endmodule // adc_input_config
`default_nettype wire

// ---- test/adc_host_model.sv ----
// Host-side model that frames chip select and the serial clock
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
  // Clock
  input  wire logic sys_clk,
  // Serial pins
  output var logic  csN,
  output var logic  sclk
);
  initial begin
    csN  = 1'b1;
    sclk = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Clock idles high and stands still between frames
  task automatic frame(input int n);
    tick(1);
    csN <= 1'b0;
    tick(4);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      tick(4);
      sclk <= 1'b1;
      tick(4);
    end
    csN <= 1'b1;
    // Leaves a full acquisition time before any later frame
    tick(30);
  endtask
endmodule // adc_host_model
`default_nettype wire

// ---- test/adc_input_config_tb.sv ----
// Self-checking bench for the input-configuration and coding block
`timescale 1ns/1ps
`default_nettype none
`include "adc_input_defs.svh"
module adc_input_config_tb;
  logic                     sys_clk, sys_rst, csN, sclk, sel, rng;
  logic [2:0]               chanAddr;
  logic                     trackMode, converting, convDone, acqDone, acqRestart;
  logic                     convHi = 1'b0;
  adc_input_pkg::conv_cfg_t cfg, e;
  int                       fails = 0, nTests = 0, rises = 0, trackAt = 0;
  int                       dones = 0, restarts = 0;
  adc_host_model host (.sys_clk(sys_clk), .csN(csN), .sclk(sclk));
  adc_input_config uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .csN(csN), .sclk(sclk),
    .inputTypeSelect(sel), .chanAddrBit0(chanAddr[0]), .chanAddrBit1(chanAddr[1]),
    .chanAddrBit2(chanAddr[2]),
    .rangeSelect(rng), .cfg(cfg), .trackMode(trackMode), .converting(converting),
    .convDone(convDone), .acqDone(acqDone), .acqRestart(acqRestart));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(negedge csN) rises = 0;
  always @(posedge sclk) if (!csN) rises++;
  always @(posedge trackMode) trackAt = rises;
  always @(posedge converting) convHi = 1'b1;
  always @(posedge sys_clk) begin
    if (convDone === 1'b1) dones++;
    if (acqRestart === 1'b1) restarts++;
  end
  task automatic check(input string what, input logic [19:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic setPins(input logic s, input logic [2:0] a, input logic r);
    @(posedge sys_clk);
    sel <= s;
    chanAddr <= a;
    rng <= r;
    repeat (7) @(posedge sys_clk);
    #1;
  endtask
  function automatic adc_input_pkg::conv_cfg_t expCfg(input logic s, input logic [2:0] a,
                                                      input logic r);
    adc_input_pkg::conv_cfg_t x;
    x = '0;
    x.addrValid = s ? (a <= 3'h5) : (a[2:1] != 2'h3);
    if (!x.addrValid) return x;
    x.doubleRange = r;
    x.lsbShift = {1'b0, r} + {1'b0, !s};
    x.coding = (r || (!s && !a[0])) ? adc_input_pkg::CODE_TWOS : adc_input_pkg::CODE_STRAIGHT;
    if (s) begin
      x.mode = adc_input_pkg::MODE_SINGLE;
      x.posSel = 6'h01 << a;
      x.negGround = 1'b1;
    end else begin
      x.mode = a[0] ? adc_input_pkg::MODE_PSEUDO_DIFF : adc_input_pkg::MODE_FULL_DIFF;
      x.posSel = 6'h01 << {a[2:1], 1'b0};
      x.negSel = 6'h02 << {a[2:1], 1'b0};
    end
    return x;
  endfunction
  initial begin
    sys_rst = 1'b1;
    sel = 1'b0;
    chanAddr = 3'h0;
    rng = 1'b0;
    // Outputs checked while still held in reset; cfg follows the pins right after release
    repeat (19) @(posedge sys_clk);
    #1;
    check("resetCfg", cfg, '0);
    check("resetTrack", 20'({converting, convDone, acqDone, acqRestart, trackMode}),
          20'h0_0001);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check("relTrack", 20'({converting, trackMode}), 20'h0_0001);
    // Every type, address and range; type flips mid-sweep and is checked seven clocks after the pins change
    for (int i = 0; i < 32; i++) begin
      setPins(i[4], i[3:1], i[0]);
      e = expCfg(i[4], i[3:1], i[0]);
      if (e.addrValid) check("cfg", cfg, e);
      else check("sel", 20'({cfg.posSel, cfg.negSel, cfg.addrValid}),
                 20'({e.posSel, e.negSel, e.addrValid}));
    end
    setPins(1'b1, 3'h2, 1'b0);
    repeat (20) @(posedge sys_clk);
    host.frame(14);
    #1;
    check("trackAt", 20'(trackAt), 20'h0_000D);
    check("dones", 20'(dones), 20'h0_0001);
    check("convEnd", 20'({convHi, converting, trackMode}), 20'h0_0005);
    // Aborted frame returns to track without a result
    host.frame(6);
    #1;
    check("abortDone", 20'(dones), 20'h0_0001);
    check("abortTrack", 20'({converting, trackMode}), 20'h0_0001);
    setPins(1'b0, 3'h0, 1'b0);
    repeat (20) @(posedge sys_clk);
    #1;
    check("acqDone", 20'(acqDone), 20'h0_0001);
    restarts = 0;
    setPins(1'b0, 3'h2, 1'b0);
    check("sameMode", 20'(restarts), 20'h0_0000);
    setPins(1'b0, 3'h3, 1'b0);
    check("restart", 20'({restarts[1:0], acqDone}), 20'h0_0002);
    repeat (`ACQ_CYCLES) @(posedge sys_clk);
    #1;
    check("reacq", 20'(acqDone), 20'h0_0001);
    conclude();
  end
  initial begin
    #50000;
    fails++;
    conclude();
  end
endmodule // adc_input_config_tb
`default_nettype wire
